// File: rtl/ftbsp_mem.sv
// Storage array of the port with per-lane writes and a registered read.
// Assumes write and read requests on the same clock; write data bypasses.
`timescale 1ns/100ps
`default_nettype none

module ftbsp_mem #(
  parameter int AW = ftbsp_pkg::ADDR_W,
  parameter int LW = ftbsp_pkg::LANE_W,
  parameter int LN = ftbsp_pkg::LANES
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [LN-1:0] wlane_i,
  input wire logic [LN*LW-1:0] wdata_i,
  input wire logic re_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [LN*LW-1:0] rdata_o
);

  logic [LN*LW-1:0] mem_r [0:(1<<AW)-1];
  logic [LN*LW-1:0] old_w;
  logic [LN*LW-1:0] cur_w;
  logic [LN*LW-1:0] merge_w;
  logic [LN*LW-1:0] rnext_w;
  wire same_w = we_i && (waddr_i == raddr_i);

  assign old_w = mem_r[waddr_i];
  assign cur_w = mem_r[raddr_i];

  genvar g;
  generate
    for (g = 0; g < LN; g++) begin : g_lane
      // unselected lanes rewrite their old contents
      assign merge_w[g*LW +: LW] = wlane_i[g] ? wdata_i[g*LW +: LW]
                                              : old_w[g*LW +: LW];
      // a read of the word being written sees the new lanes
      assign rnext_w[g*LW +: LW] = (same_w && wlane_i[g])
                                   ? wdata_i[g*LW +: LW]
                                   : cur_w[g*LW +: LW];
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= merge_w;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= '0;
    end else if (re_i) begin
      rdata_o <= rnext_w;
    end
  end

endmodule : ftbsp_mem

`default_nettype wire

// File: rtl/ftbsp_pkg.sv
// Constants and types shared by the flow-through burst memory port.
// Assumes a single core clock; all users refer to items by full scope.
package ftbsp_pkg;

  localparam int ADDR_W = 18;
  localparam int BYTE_W = 8;
  localparam int LANES = 2;
  localparam int LANE_W = BYTE_W + 1;
  localparam int DATA_W = BYTE_W * LANES;
  localparam int BEAT_W = 2;

  // sleep entry and exit each take two cycles
  localparam int SLEEP_ENTRY_CYC = 2;
  localparam int SLEEP_EXIT_CYC = 2;
  localparam int SLEEP_CNT_W = 2;

  // synchroniser lanes: output drive, sleep request, burst order strap
  localparam int SYNC_OE = 0;
  localparam int SYNC_SLEEP = 1;
  localparam int SYNC_ORDER = 2;
  localparam int SYNC_N = 3;
  localparam logic [2:0] SYNC_RST = 3'h1;

  localparam logic [1:0] BEAT_RST = 2'h0;
  localparam logic OE_N_RST = 1'b1;

  typedef enum logic [3:0] {
    SLP_AWAKE = 4'h1,
    SLP_ENTER = 4'h2,
    SLP_ASLEEP = 4'h4,
    SLP_EXIT = 4'h8
  } ftbsp_sleep_t;

endpackage : ftbsp_pkg

// File: rtl/ftbsp_port.sv
// Flow-through burst memory port: command decode, burst counter,
// delayed write, output drive control and sleep sequencing.
// Assumes the controller runs on CORE_CLK_I; output drive, sleep and
// burst order arrive asynchronously and are synchronised here.
`timescale 1ns/100ps
`default_nettype none

module ftbsp_port #(
  parameter int ADDR_W = ftbsp_pkg::ADDR_W,
  parameter int BYTE_W = ftbsp_pkg::BYTE_W,
  parameter int LANES = ftbsp_pkg::LANES
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic CYCLE_GATE_N_I,
  input wire logic CHIP_SELECT_ONE_N_I,
  input wire logic CHIP_SELECT_TWO_I,
  input wire logic CHIP_SELECT_THREE_N_I,
  input wire logic WRITE_STROBE_N_I,
  input wire logic ADVANCE_OR_LOAD_I,
  input wire logic [LANES-1:0] LANE_WRITE_SEL_N_I,
  input wire logic OUTPUT_DRIVE_N_I,
  input wire logic SLEEP_REQUEST_I,
  input wire logic BURST_ORDER_I,
  input wire logic [BYTE_W*LANES-1:0] DATA_I,
  input wire logic [LANES-1:0] PARITY_I,
  output logic [BYTE_W*LANES-1:0] DATA_O,
  output logic [LANES-1:0] PARITY_O,
  output logic DATA_OE_N_O,
  output logic PARITY_OE_N_O,
  output logic SLEEP_ACTIVE_O
);

  localparam int LW = BYTE_W + 1;
  localparam int BW = ftbsp_pkg::BEAT_W;
  localparam int CW = ftbsp_pkg::SLEEP_CNT_W;
  localparam logic [CW-1:0] ENTER_LAST = CW'(ftbsp_pkg::SLEEP_ENTRY_CYC - 1);
  localparam logic [CW-1:0] EXIT_LAST = CW'(ftbsp_pkg::SLEEP_EXIT_CYC - 1);

  // synchronisers for the asynchronous pins
  logic [ftbsp_pkg::SYNC_N-1:0] sync1_r;
  logic [ftbsp_pkg::SYNC_N-1:0] sync2_r;
  wire oe_n_s = sync2_r[ftbsp_pkg::SYNC_OE];
  wire sleep_s = sync2_r[ftbsp_pkg::SYNC_SLEEP];
  wire order_s = sync2_r[ftbsp_pkg::SYNC_ORDER];

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sync1_r <= ftbsp_pkg::SYNC_RST;
      sync2_r <= ftbsp_pkg::SYNC_RST;
    end else begin
      sync1_r <= {BURST_ORDER_I, SLEEP_REQUEST_I, OUTPUT_DRIVE_N_I};
      sync2_r <= sync1_r;
    end
  end

  // sleep sequencer
  ftbsp_pkg::ftbsp_sleep_t st_r;
  ftbsp_pkg::ftbsp_sleep_t st_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  wire awake = (st_r == ftbsp_pkg::SLP_AWAKE);

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      ftbsp_pkg::SLP_AWAKE: begin
        cnt_nxt = '0;
        if (sleep_s) begin
          st_nxt = ftbsp_pkg::SLP_ENTER;
        end
      end
      ftbsp_pkg::SLP_ENTER: begin
        cnt_nxt = CW'(cnt_r + 1'b1);
        if (cnt_r == ENTER_LAST) begin
          st_nxt = ftbsp_pkg::SLP_ASLEEP;
          cnt_nxt = '0;
        end
      end
      ftbsp_pkg::SLP_ASLEEP: begin
        cnt_nxt = '0;
        if (!sleep_s) begin
          st_nxt = ftbsp_pkg::SLP_EXIT;
        end
      end
      ftbsp_pkg::SLP_EXIT: begin
        cnt_nxt = CW'(cnt_r + 1'b1);
        if (cnt_r == EXIT_LAST) begin
          st_nxt = ftbsp_pkg::SLP_AWAKE;
          cnt_nxt = '0;
        end
      end
      default: begin
        st_nxt = ftbsp_pkg::SLP_AWAKE;
        cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st_r <= ftbsp_pkg::SLP_AWAKE;
      cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // command decode
  logic active_r;
  logic dir_wr_r;
  logic order_r;
  logic [BW-1:0] start_r;
  logic [BW-1:0] beat_r;
  logic [ADDR_W-BW-1:0] hi_r;
  logic rd_live_r;
  logic wpend_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [LANES-1:0] wlane_r;
  logic oe_n_r;

  wire qual = awake && !CYCLE_GATE_N_I;
  wire cs_all = !CHIP_SELECT_ONE_N_I && CHIP_SELECT_TWO_I
                && !CHIP_SELECT_THREE_N_I;
  wire load = qual && !ADVANCE_OR_LOAD_I;
  wire adv_go = qual && ADVANCE_OR_LOAD_I && active_r;
  wire start_rd = load && cs_all && WRITE_STROBE_N_I;
  wire start_wr = load && cs_all && !WRITE_STROBE_N_I;
  wire rd_beat = start_rd || (adv_go && !dir_wr_r);
  wire wr_beat = start_wr || (adv_go && dir_wr_r);

  // burst address: only the low two bits move, wrapping
  wire [BW-1:0] beat_inc = BW'(beat_r + 2'h1);
  wire [BW-1:0] cur_low = order_r ? (start_r ^ beat_r)
                                  : BW'(start_r + beat_r);
  wire [BW-1:0] low_adv = order_r ? (start_r ^ beat_inc)
                                  : BW'(start_r + beat_inc);
  wire [ADDR_W-1:0] acc_addr = load ? ADDR_I : {hi_r, low_adv};

  wire rd_live_nxt = awake && (qual ? rd_beat : rd_live_r);
  wire drive_nxt = rd_live_nxt && !oe_n_s;

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      active_r <= 1'b0;
      dir_wr_r <= 1'b0;
      order_r <= 1'b0;
      start_r <= ftbsp_pkg::BEAT_RST;
      beat_r <= ftbsp_pkg::BEAT_RST;
      hi_r <= '0;
    end else if (!awake) begin
      active_r <= 1'b0;
    end else if (load) begin
      active_r <= cs_all;
      beat_r <= ftbsp_pkg::BEAT_RST;
      if (cs_all) begin
        dir_wr_r <= !WRITE_STROBE_N_I;
        order_r <= order_s;
        start_r <= ADDR_I[BW-1:0];
        hi_r <= ADDR_I[ADDR_W-1:BW];
      end
    end else if (adv_go) begin
      beat_r <= beat_inc;
    end
  end

  // write data follow one qualified edge after the command
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rd_live_r <= 1'b0;
      wpend_r <= 1'b0;
      waddr_r <= '0;
      wlane_r <= '0;
      oe_n_r <= ftbsp_pkg::OE_N_RST;
    end else begin
      rd_live_r <= rd_live_nxt;
      oe_n_r <= !drive_nxt;
      if (!awake) begin
        wpend_r <= 1'b0;
      end else if (qual) begin
        wpend_r <= wr_beat;
        if (wr_beat) begin
          waddr_r <= acc_addr;
          wlane_r <= ~LANE_WRITE_SEL_N_I;
        end
      end
    end
  end

  // lane packing: each lane is its byte with its parity bit on top
  logic [LANES*LW-1:0] wdata_w;
  logic [LANES*LW-1:0] rdata_w;
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign wdata_w[g*LW +: LW] = {PARITY_I[g], DATA_I[g*BYTE_W +: BYTE_W]};
      assign DATA_O[g*BYTE_W +: BYTE_W] = rdata_w[g*LW +: BYTE_W];
      assign PARITY_O[g] = rdata_w[g*LW + BYTE_W];
    end
  endgenerate

  ftbsp_mem #(
    .AW(ADDR_W),
    .LW(LW),
    .LN(LANES)
  ) u_mem (
    .clk_i(CORE_CLK_I),
    .rst_b_i(RST_B_I),
    .we_i(wpend_r && qual),
    .waddr_i(waddr_r),
    .wlane_i(wlane_r),
    .wdata_i(wdata_w),
    .re_i(qual && rd_beat),
    .raddr_i(acc_addr),
    .rdata_o(rdata_w)
  );

  assign DATA_OE_N_O = oe_n_r;
  assign PARITY_OE_N_O = oe_n_r;
  assign SLEEP_ACTIVE_O = st_r[2];

  // checks
  a_gate_holds:
  assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
    CYCLE_GATE_N_I && awake |=> $stable(beat_r) && $stable(active_r)
      && $stable(wpend_r) && $stable(rd_live_r) && $stable(DATA_O))
    else $error("gated edge changed state");

  a_read_start:
  assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
    start_rd |=> rd_live_r && active_r && !dir_wr_r
      && {hi_r, start_r} == $past(ADDR_I))
    else $error("read start not captured");

  a_read_drive:
  assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
    rd_beat && !oe_n_s |=> !DATA_OE_N_O && !PARITY_OE_N_O)
    else $error("read beat not driven next cycle");

  a_desel_release:
  assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
    load && !cs_all |=> DATA_OE_N_O && PARITY_OE_N_O && !active_r)
    else $error("deselect left bus driven");

  a_beat_advance:
  assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
    adv_go |=> beat_r == BW'($past(beat_r) + 2'h1) && $stable(dir_wr_r))
    else $error("advance did not step the burst");

  a_burst_linear:
  assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
    adv_go && !order_r |=> cur_low == BW'($past(cur_low) + 2'h1))
    else $error("linear burst address wrong");

  a_burst_intlv:
  assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
    adv_go && order_r |=> (cur_low ^ start_r) == BW'($past(beat_r) + 2'h1))
    else $error("interleaved burst address wrong");

  a_write_commit:
  assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
    wr_beat |=> wpend_r && waddr_r == $past(acc_addr)
      && wlane_r == ~$past(LANE_WRITE_SEL_N_I))
    else $error("write beat not pending next cycle");

  a_write_release:
  assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
    start_wr |=> DATA_OE_N_O && wpend_r)
    else $error("bus driven in write data phase");

  a_sleep_entry:
  assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
    awake && sleep_s |=> st_r == ftbsp_pkg::SLP_ENTER
      ##1 st_r == ftbsp_pkg::SLP_ENTER ##1 st_r == ftbsp_pkg::SLP_ASLEEP)
    else $error("sleep entry not two cycles");

  a_sleep_drop:
  assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
    !awake |=> !wpend_r && !rd_live_r && DATA_OE_N_O)
    else $error("access survived sleep entry");

endmodule : ftbsp_port

`default_nettype wire

// File: tb/ftbsp_ctrl_model.sv
// Controller-side data bus model for the memory port bench.
// Assumes the bench says in which cycles the controller drives write data.
`timescale 1ns/100ps
`default_nettype none

module ftbsp_ctrl_model (
  input wire logic clk_i,
  input wire logic drv_i,
  input wire logic [17:0] word_i,
  input wire logic dev_oe_n_i,
  output logic [15:0] data_o,
  output logic [1:0] parity_o,
  output logic clash_o
);
  // released bus toggles each cycle so a stale value never looks valid
  logic [17:0] last_r = 18'h15555;
  logic clash_r = 1'b0;

  always @(posedge clk_i) begin
    last_r <= drv_i ? word_i : ~last_r;
    if (drv_i && !dev_oe_n_i) begin
      clash_r <= 1'b1;
    end
  end

  assign {parity_o, data_o} = drv_i ? word_i : ~last_r;
  assign clash_o = clash_r;
endmodule : ftbsp_ctrl_model

`default_nettype wire

// File: tb/test_ftbsp_port.sv
// Self-checking bench for the flow-through burst memory port.
// Assumes the controller bus model drives the write data lines.
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("FAIL %s exp %h got %h", nm, e, g); \
    end \
  end

module test_ftbsp_port;
  localparam logic [2:0] ON = 3'h2;
  localparam logic [2:0] OFF = 3'h6;
  localparam logic [17:0] W1 = 18'h2A5C3;
  localparam logic [17:0] W2 = 18'h13C7E;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic gate_n = 1'b0;
  logic [2:0] sel = OFF;
  logic we_n = 1'b1;
  logic adv = 1'b0;
  logic [17:0] addr = 18'h00000;
  logic [1:0] lanes = 2'h3;
  logic oe_n = 1'b0;
  logic sleep = 1'b0;
  logic order = 1'b0;
  logic drv = 1'b0;
  logic [17:0] word = 18'h00000;
  logic [15:0] d_in, d_out;
  logic [1:0] p_in, p_out;
  logic doe_n, poe_n, slp_act, clash;
  int bad_count = 0;
  int check_count = 0;

  always #10 clk = ~clk;

  ftbsp_port dut_u (
    .CORE_CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr),
    .CYCLE_GATE_N_I(gate_n), .CHIP_SELECT_ONE_N_I(sel[2]),
    .CHIP_SELECT_TWO_I(sel[1]), .CHIP_SELECT_THREE_N_I(sel[0]),
    .WRITE_STROBE_N_I(we_n), .ADVANCE_OR_LOAD_I(adv),
    .LANE_WRITE_SEL_N_I(lanes), .OUTPUT_DRIVE_N_I(oe_n),
    .SLEEP_REQUEST_I(sleep), .BURST_ORDER_I(order),
    .DATA_I(d_in), .PARITY_I(p_in), .DATA_O(d_out), .PARITY_O(p_out),
    .DATA_OE_N_O(doe_n), .PARITY_OE_N_O(poe_n), .SLEEP_ACTIVE_O(slp_act)
  );

  ftbsp_ctrl_model bus_u (
    .clk_i(clk), .drv_i(drv), .word_i(word), .dev_oe_n_i(doe_n),
    .data_o(d_in), .parity_o(p_in), .clash_o(clash)
  );

  function automatic logic [17:0] bw(input logic [1:0] k);
    return {k, 14'h2C00, k};
  endfunction : bw

  task automatic give_verdict();
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // one bus cycle; values are sampled at the following rising edge
  task automatic cyc(input logic a, input logic w, input logic [2:0] s,
      input logic [17:0] ad, input logic [1:0] l, input logic dv,
      input logic [17:0] wd);
    @(posedge clk);
    gate_n <= 1'b0;
    adv <= a;
    we_n <= w;
    sel <= s;
    addr <= ad;
    lanes <= l;
    drv <= dv;
    word <= wd;
  endtask : cyc

  task automatic t_wr_rd();
    cyc(0, 0, ON, 18'h00010, 2'h0, 0, 0);
    cyc(0, 1, ON, 18'h00010, 2'h3, 1, W1);
    #1;
    `CHK("wr_oe", 2'h3, {poe_n, doe_n})
    cyc(0, 1, OFF, 0, 2'h3, 0, 0);
    #1;
    `CHK("rd_data", W1, {p_out, d_out})
    `CHK("rd_oe", 2'h0, {poe_n, doe_n})
  endtask : t_wr_rd

  task automatic t_byte_gate();
    cyc(0, 0, ON, 18'h00010, 2'h2, 0, 0);
    cyc(0, 1, ON, 18'h00010, 2'h3, 1, W2);
    @(posedge clk);
    gate_n <= 1'b1;
    sel <= OFF;
    drv <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("byte_data", 18'h3A57E, {p_out, d_out})
    `CHK("gate_oe", 2'h0, {poe_n, doe_n})
    cyc(0, 1, OFF, 0, 2'h3, 0, 0);
    cyc(0, 1, OFF, 0, 2'h3, 0, 0);
    #1;
    `CHK("desel_oe", 2'h3, {poe_n, doe_n})
  endtask : t_byte_gate

  task automatic t_deselect();
    logic [2:0] bad [3] = '{3'h0, 3'h3, 3'h6};
    for (int i = 0; i < 3; i++) begin
      cyc(0, 1, ON, 18'h00010, 2'h3, 0, 0);
      cyc(0, 1, bad[i], 18'h00010, 2'h3, 0, 0);
      cyc(0, 1, OFF, 0, 2'h3, 0, 0);
      #1;
      `CHK("cs_oe", 2'h3, {poe_n, doe_n})
    end
  endtask : t_deselect

  // drive enable held high: a read must leave the bus released
  task automatic t_oe_off();
    @(posedge clk);
    oe_n <= 1'b1;
    repeat (3) cyc(0, 1, OFF, 0, 2'h3, 0, 0);
    cyc(0, 1, ON, 18'h00010, 2'h3, 0, 0);
    cyc(0, 1, OFF, 0, 2'h3, 0, 0);
    #1;
    `CHK("oe_masked", 2'h3, {poe_n, doe_n})
    `CHK("masked_data", 18'h3A57E, {p_out, d_out})
    @(posedge clk);
    oe_n <= 1'b0;
  endtask : t_oe_off

  // write burst from low bits 01; advances drop selects and strobe
  task automatic t_burst_wr();
    cyc(0, 0, ON, 18'h00021, 2'h0, 0, 0);
    for (int k = 0; k < 4; k++) begin
      cyc(k < 3, 1, OFF, 0, 2'h0, 1, bw(2'(k)));
    end
    cyc(0, 1, OFF, 0, 2'h3, 0, 0);
  endtask : t_burst_wr

  task automatic t_rd_burst(input logic o, input logic [17:0] st);
    logic [1:0] lo;
    @(posedge clk);
    order <= o;
    repeat (3) cyc(0, 1, OFF, 0, 2'h3, 0, 0);
    cyc(0, 1, ON, st, 2'h3, 0, 0);
    for (int j = 0; j < 4; j++) begin
      // strobe low on advances: direction must stay read
      cyc(j < 3, 0, OFF, 0, 2'h3, 0, 0);
      #1;
      lo = o ? st[1:0] ^ 2'(j) : st[1:0] + 2'(j);
      `CHK("burst", bw(lo - 2'h1), {p_out, d_out})
    end
  endtask : t_rd_burst

  task automatic wait_for(input logic v);
    // look after the edge has settled, not in its own time step
    for (int n = 0; n < 8 && slp_act !== v; n++) begin
      @(posedge clk);
      #1;
    end
    if (slp_act !== v) begin
      bad_count++;
      $display("FAIL sleep_wait exp %h got %h", v, slp_act);
      give_verdict();
    end
  endtask : wait_for

  task automatic t_sleep();
    @(posedge clk);
    sleep <= 1'b1;
    // two synchroniser edges, then two entry cycles
    repeat (4) @(posedge clk);
    #1;
    `CHK("sleep_early", 1'b0, slp_act)
    @(posedge clk);
    #1;
    `CHK("sleep_on", 1'b1, slp_act)
    wait_for(1'b1);
    `CHK("sleep_oe", 2'h3, {poe_n, doe_n})
    @(posedge clk);
    sleep <= 1'b0;
    wait_for(1'b0);
    repeat (2) cyc(0, 1, OFF, 0, 2'h3, 0, 0);
    cyc(0, 1, ON, 18'h00010, 2'h3, 0, 0);
    cyc(0, 1, OFF, 0, 2'h3, 0, 0);
    #1;
    `CHK("sleep_keep", 18'h3A57E, {p_out, d_out})
  endtask : t_sleep

  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    `CHK("oe_reset", 2'h3, {poe_n, doe_n})
    repeat (3) @(posedge clk);
    t_wr_rd();
    t_byte_gate();
    t_deselect();
    t_oe_off();
    t_burst_wr();
    t_rd_burst(1'b0, 18'h00022);
    t_rd_burst(1'b1, 18'h00021);
    t_sleep();
    `CHK("bus_clash", 1'b0, clash)
    give_verdict();
  end
endmodule : test_ftbsp_port

`default_nettype wire
